/* File: fpb_fan_source_binding.sv */
// Fan output source binding, hot input monitoring and duty selection
// Summary of operation
// - One byte holds two 4-bit window codes, low for cpu hot one.
// - Code 0h gives 0.73 s, doubling per code to 9h; Ah-Fh reserved.
// - Binding bits 0-3 tie the output to temperature zones one to four.
// - Binding bits 4-5 tie the output to cpu hot inputs one and two.
// - Binding bits 6-7 tie the output to regulator hot inputs.
// - Bound zones request duty through the lookup table.
// - Bound hot inputs request duty through ramp up and ramp down.
// - Several bound sources: largest requested duty wins.
// - Lock enabled plus bound cpu hot event forces full duty, sets flag.
// - Invert bit chooses whether full duty is steady high or low.
`timescale 1ns/100ps
`default_nettype none
module fpb_fan_source_binding
  import fpb_pkg::*;
#(
  parameter longint BASE_WINDOW_CYCLES = FPB_BASE_WINDOW_CYC,
  parameter longint RAMP_STEP_CYCLES   = FPB_RAMP_STEP_CYC
) (
  input  wire logic            core_clk,        // 10 MHz core clock
  input  wire logic            rst,             // Synchronous reset
  input  wire logic [7:0]      regAddr,         // Register byte address
  input  wire logic [7:0]      regWrData,       // Write data byte
  input  wire logic            regWrEn,         // Write strobe
  input  wire logic            regRdEn,         // Read strobe
  output logic      [7:0]      regRdData,       // Read data, next cycle
  input  wire logic [3:0][3:0] zoneLookupDuty,  // Lookup duty per zone
  input  wire logic            firstCpuHotInputN,        // Pin, low = hot
  input  wire logic            secondCpuHotInputN,       // Pin, low = hot
  input  wire logic            firstRegulatorHotInputN,  // Pin, low = hot
  input  wire logic            secondRegulatorHotInputN, // Pin, low = hot
  output logic      [1:0]      cpuHotSeenInWindow, // Last window result
  output logic                 hotFullDutyLockFlag, // Lock flag
  output logic      [3:0]      currentDuty,     // Duty code in use
  output logic                 fanOutputA       // Fan PWM output
);

  fpb_state_t st;
  fpb_state_t next_st;

  // Window length for a code; reserved codes fall back to the longest
  function automatic logic [31:0] windowCycles(input logic [3:0] code);
    logic [3:0]   c;
    logic [63:0]  w;
    c = (code > FPB_LAST_INTERVAL_CODE) ? FPB_LAST_INTERVAL_CODE : code;
    w = 64'(BASE_WINDOW_CYCLES) << c;
    return w[31:0];
  endfunction : windowCycles

  function automatic logic [3:0] maxDuty(input logic [3:0] a,
                                         input logic [3:0] b);
    return (a > b) ? a : b;
  endfunction : maxDuty

  logic [3:0] hotNow;
  logic [3:0] req;
  logic       rampTick;
  logic       cpuHotEvent;
  logic       wrOverride;

  always_comb begin
    next_st    = st;
    hotNow     = ~st.syncB;
    rampTick   = (st.rampDiv == 32'(RAMP_STEP_CYCLES - 1));
    wrOverride = regWrEn && (regAddr == FPB_OFS_OVERRIDE);
    req        = 4'h0;

    // Two-flop synchronisers on the hot pins
    next_st.syncA = {secondRegulatorHotInputN, firstRegulatorHotInputN,
                     secondCpuHotInputN, firstCpuHotInputN};
    next_st.syncB = st.syncA;
    next_st.cpuHotPrev = hotNow[1:0];

    // Register writes; window codes are taken as written
    if (regWrEn && regAddr == FPB_OFS_INTERVAL) begin
      next_st.interval = regWrData;
    end
    if (regWrEn && regAddr == FPB_OFS_BINDING) begin
      next_st.binding = regWrData;
    end
    if (wrOverride) begin
      next_st.manualEn   = regWrData[FPB_MANUAL_ENABLE_BIT];
      next_st.invert     = regWrData[FPB_INVERT_BIT];
      next_st.lockEn     = regWrData[FPB_LOCK_ENABLE_BIT];
      next_st.manualDuty = regWrData[FPB_MANUAL_DUTY_LSB +: 4];
      // Flag clears only by writing zero; writing one leaves it alone
      if (!regWrData[FPB_LOCK_FLAG_BIT]) begin
        next_st.lockFlag = 1'b0;
      end
    end

    // Monitoring windows, one per cpu hot input
    for (int i = 0; i < 2; i++) begin
      if (st.winCnt[i] >= windowCycles(st.interval[4*i +: 4]) - 32'd1) begin
        next_st.winCnt[i]   = 32'd0;
        next_st.seenLast[i] = st.seenNow[i] | hotNow[i];
        next_st.seenNow[i]  = 1'b0;
      end else begin
        next_st.winCnt[i]  = st.winCnt[i] + 32'd1;
        next_st.seenNow[i] = st.seenNow[i] | hotNow[i];
      end
    end

    // Ramp functions for every hot input
    next_st.rampDiv = rampTick ? 32'd0 : st.rampDiv + 32'd1;
    for (int i = 0; i < 4; i++) begin
      if (rampTick) begin
        if (hotNow[i] && st.ramp[i] != FPB_FULL_DUTY) begin
          next_st.ramp[i] = st.ramp[i] + 4'h1;
        end else if (!hotNow[i] && st.ramp[i] != 4'h0) begin
          next_st.ramp[i] = st.ramp[i] - 4'h1;
        end
      end
    end

    // Largest request among bound sources
    for (int i = 0; i < 4; i++) begin
      if (st.binding[FPB_BIND_ZONE_LSB + i]) begin
        req = maxDuty(req, zoneLookupDuty[i]);
      end
    end
    for (int i = 0; i < 2; i++) begin
      if (st.binding[FPB_BIND_CPU_HOT_LSB + i]) begin
        req = maxDuty(req, st.ramp[i]);
      end
      if (st.binding[FPB_BIND_REG_HOT_LSB + i]) begin
        req = maxDuty(req, st.ramp[2 + i]);
      end
    end
    // Manual value joins the contest, so a greater request still wins
    if (st.manualEn) begin
      req = maxDuty(req, st.manualDuty);
    end

    // Lock on a newly asserted bound cpu hot input; set beats clear
    cpuHotEvent = |(hotNow[1:0] & ~st.cpuHotPrev &
                    st.binding[FPB_BIND_CPU_HOT_LSB +: 2]);
    if (st.lockEn && cpuHotEvent) begin
      next_st.lockFlag = 1'b1;
    end
    if (st.lockFlag) begin
      req = FPB_FULL_DUTY;
    end
    next_st.duty = req;

    // PWM of sixteen slots; full code holds the level for the whole period
    if (st.slotDiv == 8'(FPB_PWM_SLOT_CYC - 1)) begin
      next_st.slotDiv = 8'h00;
      next_st.pwmCnt  = st.pwmCnt + 4'h1;
    end else begin
      next_st.slotDiv = st.slotDiv + 8'h01;
    end
    next_st.pwm = ((st.pwmCnt < st.duty) || (st.duty == FPB_FULL_DUTY))
                  ^ st.invert;

    // Read path; the duty field shows the duty in use, not the written one
    if (regRdEn) begin
      case (regAddr)
        FPB_OFS_INTERVAL: next_st.rdData = st.interval;
        FPB_OFS_BINDING:  next_st.rdData = st.binding;
        FPB_OFS_OVERRIDE: next_st.rdData = {st.duty, st.lockFlag,
                                            st.lockEn, st.invert,
                                            st.manualEn};
        default:          next_st.rdData = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st            <= '0;
      st.interval   <= FPB_RST_INTERVAL;
      st.binding    <= FPB_RST_BINDING;
      st.manualEn   <= FPB_RST_OVERRIDE[FPB_MANUAL_ENABLE_BIT];
      st.invert     <= FPB_RST_OVERRIDE[FPB_INVERT_BIT];
      st.lockEn     <= FPB_RST_OVERRIDE[FPB_LOCK_ENABLE_BIT];
      st.lockFlag   <= FPB_RST_OVERRIDE[FPB_LOCK_FLAG_BIT];
      st.manualDuty <= FPB_RST_OVERRIDE[FPB_MANUAL_DUTY_LSB +: 4];
      st.syncA      <= 4'hF;
      st.syncB      <= 4'hF;
    end else begin
      st <= next_st;
    end
  end

  assign regRdData           = st.rdData;
  assign cpuHotSeenInWindow  = st.seenLast;
  assign hotFullDutyLockFlag = st.lockFlag;
  assign currentDuty         = st.duty;
  assign fanOutputA          = st.pwm;

endmodule : fpb_fan_source_binding
`default_nettype wire

/* File: fpb_hot_model.sv */
// Hot alarm sources: pins follow requests after LAG cycles
`timescale 1ns/100ps
`default_nettype none
module fpb_hot_model #(
  parameter int LAG = 3
) (
  input  wire logic [3:0] hotReq,   // Bit i asks pin i hot
  input  wire logic       core_clk, // Clock
  output logic      [3:0] hotPinN   // Active low, pulled up idle
);
  logic [LAG-1:0][3:0] pipe = '0;
  // Lag of two or more models a slow source
  always @(posedge core_clk) pipe <= {pipe[LAG-2:0], hotReq};
  assign hotPinN = ~pipe[LAG-1];
endmodule : fpb_hot_model
`default_nettype wire

/* File: fpb_monitor.sv */
// Port assertions for the fan source binding block
`timescale 1ns/100ps
`default_nettype none
module fpb_monitor (
  input wire logic       core_clk,            // Clock
  input wire logic       rst,                 // Sync reset
  input wire logic [7:0] regAddr,             // Address
  input wire logic [7:0] regWrData,           // Write byte
  input wire logic       regWrEn,             // Write strobe
  input wire logic       regRdEn,             // Read strobe
  input wire logic [7:0] regRdData,           // Read byte
  input wire logic       firstCpuHotInputN,   // Hot pin
  input wire logic       secondCpuHotInputN,  // Hot pin
  input wire logic [1:0] cpuHotSeenInWindow,  // Window result
  input wire logic       hotFullDutyLockFlag, // Lock flag
  input wire logic [3:0] currentDuty,         // Duty in use
  input wire logic       fanOutputA           // PWM output
);
  logic [3:0] lowHist;
  // Pin history, since the lock trails the pin by a sync chain
  always_ff @(posedge core_clk) begin
    if (rst) lowHist <= 4'h0;
    else lowHist <= {lowHist[2:0], ~(firstCpuHotInputN & secondCpuHotInputN)};
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  a_lock_full_duty: assert property (hotFullDutyLockFlag |=>
    currentDuty == 4'hF) else $error("lock without full duty");
  a_lock_needs_hot: assert property ($rose(hotFullDutyLockFlag) |->
    |lowHist) else $error("lock set with no hot pin");
  a_lock_clear_write: assert property ($fell(hotFullDutyLockFlag) |->
    $past(regWrEn && regAddr == 8'hC9 && !regWrData[3]))
    else $error("lock cleared without write");
  a_full_steady_out: assert property (
    (currentDuty == 4'hF && !regWrEn)[*3] |=>
    $stable(fanOutputA)) else $error("full duty output toggles");
  a_read_data_holds: assert property (!regRdEn |=>
    $stable(regRdData)) else $error("read data moved");
  a_unmapped_read: assert property (regRdEn && !(regAddr inside
    {8'hC7, 8'hC8, 8'hC9}) |=> regRdData == 8'h00)
    else $error("unmapped read not zero");
  a_binding_readback: assert property (regWrEn && regAddr == 8'hC8 ##1
    regRdEn && !regWrEn && regAddr == 8'hC8 |=>
    regRdData == $past(regWrData, 2))
    else $error("binding readback wrong");
  a_interval_readback: assert property (regWrEn && regAddr == 8'hC7 ##1
    regRdEn && !regWrEn && regAddr == 8'hC7 |=>
    regRdData == $past(regWrData, 2))
    else $error("interval readback wrong");
  a_duty_readout: assert property (regRdEn && regAddr == 8'hC9 |=>
    regRdData[7:4] == $past(currentDuty)) else $error("duty readout wrong");
  cover property ($rose(hotFullDutyLockFlag));
  cover property (currentDuty == 4'hF && !hotFullDutyLockFlag);
  cover property ($rose(cpuHotSeenInWindow[0]));
endmodule : fpb_monitor
bind fpb_fan_source_binding fpb_monitor i_fpb_monitor (.core_clk, .rst,
  .regAddr, .regWrData, .regWrEn, .regRdEn, .regRdData, .firstCpuHotInputN,
  .secondCpuHotInputN, .cpuHotSeenInWindow, .hotFullDutyLockFlag,
  .currentDuty, .fanOutputA);
`default_nettype wire

/* File: fpb_pkg.sv */
// Constants and state type for the fan output source binding block
package fpb_pkg;

  // Register offsets on the byte register port
  localparam logic [7:0] FPB_OFS_INTERVAL = 8'hC7;
  localparam logic [7:0] FPB_OFS_BINDING  = 8'hC8;
  localparam logic [7:0] FPB_OFS_OVERRIDE = 8'hC9;

  // Values after reset
  localparam logic [7:0] FPB_RST_INTERVAL = 8'h11;
  localparam logic [7:0] FPB_RST_BINDING  = 8'h0F;
  localparam logic [7:0] FPB_RST_OVERRIDE = 8'h00;

  // Interval byte fields
  localparam int FPB_FIRST_HOT_INTERVAL_LSB  = 0;
  localparam int FPB_SECOND_HOT_INTERVAL_LSB = 4;

  // Binding byte fields
  localparam int FPB_BIND_ZONE_LSB     = 0;
  localparam int FPB_BIND_CPU_HOT_LSB  = 4;
  localparam int FPB_BIND_REG_HOT_LSB  = 6;

  // Override byte fields
  localparam int FPB_MANUAL_ENABLE_BIT = 0;
  localparam int FPB_INVERT_BIT        = 1;
  localparam int FPB_LOCK_ENABLE_BIT   = 2;
  localparam int FPB_LOCK_FLAG_BIT     = 3;
  localparam int FPB_MANUAL_DUTY_LSB   = 4;

  // Interval codes: 0h is the shortest window, 9h the longest
  localparam logic [3:0] FPB_LAST_INTERVAL_CODE = 4'h9;

  // Clock and timing
  localparam longint FPB_CLK_HZ           = 10000000;
  localparam longint FPB_BASE_WINDOW_US   = 730000;
  localparam longint FPB_BASE_WINDOW_CYC  =
    (FPB_BASE_WINDOW_US * FPB_CLK_HZ) / 1000000;
  localparam longint FPB_RAMP_STEP_MS     = 100;
  localparam longint FPB_RAMP_STEP_CYC    =
    (FPB_RAMP_STEP_MS * FPB_CLK_HZ) / 1000;
  localparam longint FPB_PWM_SLOT_US      = 3;
  localparam int     FPB_PWM_SLOT_CYC     =
    int'((FPB_PWM_SLOT_US * FPB_CLK_HZ) / 1000000);

  localparam logic [3:0] FPB_FULL_DUTY = 4'hF;

  typedef struct packed {
    logic [7:0]      interval;
    logic [7:0]      binding;
    logic            manualEn;
    logic            invert;
    logic            lockEn;
    logic            lockFlag;
    logic [3:0]      manualDuty;
    logic [3:0]      syncA;
    logic [3:0]      syncB;
    logic [1:0]      cpuHotPrev;
    logic [1:0][31:0] winCnt;
    logic [1:0]      seenNow;
    logic [1:0]      seenLast;
    logic [3:0][3:0] ramp;
    logic [31:0]     rampDiv;
    logic [7:0]      slotDiv;
    logic [3:0]      pwmCnt;
    logic [3:0]      duty;
    logic            pwm;
    logic [7:0]      rdData;
  } fpb_state_t;

endpackage : fpb_pkg

/* File: tb_fpb_fan_source_binding.sv */
// Self-checking bench for the fan source binding block
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin errors++; \
  $display("Error %0t: got %h want %h", $time, a, b); end end
module tb_fpb_fan_source_binding;
  logic            core_clk = 0, rst = 1, regWrEn = 0, regRdEn = 0, en;
  logic [7:0]      regAddr = 0, regWrData = 0, regRdData, rdv, bnd;
  logic [3:0][3:0] zoneLookupDuty = 0;
  logic [3:0]      hotReq = 0, hotPinN, currentDuty, expDuty, man;
  logic [1:0]      seen;
  logic            lockFlag, fanOut;
  int              errors = 0, comparisons = 0, seed = 32'h3dbc;
  fpb_fan_source_binding #(.BASE_WINDOW_CYCLES(20), .RAMP_STEP_CYCLES(4))
    i_fpb_fan_source_binding (.core_clk(core_clk), .rst(rst),
    .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regRdData(regRdData), .zoneLookupDuty(zoneLookupDuty),
    .firstCpuHotInputN(hotPinN[0]), .secondCpuHotInputN(hotPinN[1]),
    .firstRegulatorHotInputN(hotPinN[2]), .secondRegulatorHotInputN(hotPinN[3]),
    .cpuHotSeenInWindow(seen), .hotFullDutyLockFlag(lockFlag),
    .currentDuty(currentDuty), .fanOutputA(fanOut));
  fpb_hot_model i_fpb_hot_model (.hotReq(hotReq), .core_clk(core_clk),
    .hotPinN(hotPinN));
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge core_clk);
    regWrEn <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    regAddr <= a;
    regWrEn <= 1'b0;
    regRdEn <= 1'b1;
    @(posedge core_clk);
    regRdEn <= 1'b0;
    #1 rdv = regRdData;
  endtask : rd
  task automatic idle(input int n);
    repeat (n) @(posedge core_clk) regWrEn <= 1'b0;
  endtask : idle
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : final_report
  initial begin
    forever #50 core_clk = ~core_clk;
  end
  initial begin
    #(6000 * 100);
    errors++;
    final_report();
  end
  initial begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    rd(8'hC7);
    `CHK(rdv, 8'h11)
    rd(8'hC8);
    `CHK(rdv, 8'h0F)
    rd(8'hC9);
    `CHK(rdv, 8'h00)
    wr(8'hC6, 8'hFF);
    rd(8'hC6);
    `CHK(rdv, 8'h00)
    wr(8'hC7, 8'h10);
    rd(8'hC7);
    `CHK(rdv, 8'h10)
    $display("Test registers done");
    for (int i = 0; i < 20; i++) begin
      bnd = 8'($random(seed));
      man = 4'($random(seed));
      en = 1'($random(seed));
      @(posedge core_clk) zoneLookupDuty <= 16'($random(seed));
      wr(8'hC8, bnd);
      wr(8'hC9, {man, 3'b000, en});
      idle(4);
      expDuty = en ? man : 4'h0;
      for (int z = 0; z < 4; z++) begin
        if (bnd[z] && zoneLookupDuty[z] > expDuty) expDuty = zoneLookupDuty[z];
      end
      `CHK(currentDuty, expDuty)
      rd(8'hC9);
      `CHK(rdv[7:4], expDuty)
    end
    $display("Test duty max done");
    wr(8'hC8, 8'h10);
    wr(8'hC9, 8'h04);
    @(posedge core_clk) hotReq <= 4'h1;
    idle(12);
    `CHK(lockFlag, 1'b1)
    `CHK(currentDuty, 4'hF)
    `CHK(fanOut, 1'b1)
    wr(8'hC9, 8'h0E);
    idle(4);
    `CHK(fanOut, 1'b0)
    `CHK(lockFlag, 1'b1)
    @(posedge core_clk) hotReq <= 4'h0;
    wr(8'hC9, 8'h00);
    idle(4);
    `CHK(lockFlag, 1'b0)
    $display("Test lock done");
    // Each hot input alone ramps to full and back
    for (int k = 0; k < 4; k++) begin
      wr(8'hC8, 8'h10 << k);
      @(posedge core_clk) hotReq <= 4'h1 << k;
      idle(90);
      `CHK(currentDuty, 4'hF)
      `CHK(lockFlag, 1'b0)
      @(posedge core_clk) hotReq <= 4'h0;
      idle(90);
      `CHK(currentDuty, 4'h0)
    end
    $display("Test ramps done");
    @(posedge core_clk) hotReq <= 4'h1;
    idle(70);
    `CHK(seen, 2'b01)
    @(posedge core_clk) hotReq <= 4'h0;
    idle(70);
    `CHK(seen, 2'b00)
    $display("Test windows done");
    final_report();
  end
endmodule : tb_fpb_fan_source_binding
`default_nettype wire
